/* pkg/nand_host_pkg.sv */
// Types of the NAND status and column-read host controller.
// Assumes nothing beyond a SystemVerilog compiler.
package nand_host_pkg;

  // ==========================================================
  // Operations that software starts
  typedef enum logic [2:0] {
    OP_STATUS = 3'h0,
    OP_STATUS_ENH = 3'h1,
    OP_READ_MODE = 3'h2,
    OP_RAND_READ = 3'h3,
    OP_READ_DATA = 3'h4,
    OP_POLL = 3'h5
  } op_type;

  // ==========================================================
  // Bus cycle kinds of the pin sequencer
  typedef enum logic [2:0] {
    K_CMD = 3'h0,
    K_ADDR = 3'h1,
    K_READ = 3'h2,
    K_DELAY = 3'h3,
    K_LIVE = 3'h4
  } kind_type;

  typedef struct packed {
    kind_type kind;
    logic [7:0] data;
    logic last;
    logic to_status;
  } micro_type;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_SETUP = 3'h1,
    S_LOW = 3'h2,
    S_HIGH = 3'h3,
    S_WAIT = 3'h4,
    S_LIVE = 3'h5
  } seq_state_type;

endpackage

/* pkg/nand_host_regs.svh */
// Constants of the NAND status and column-read host controller.
// Assumes a 250 MHz pclk and an 8-bit asynchronous NAND bus.
`ifndef NAND_HOST_REGS_SVH
`define NAND_HOST_REGS_SVH

// ==========================================================
// Timing
`define CLK_PERIOD_NS 4
`define T_WP_NS 15
`define T_WH_NS 10
`define T_RP_NS 15
`define T_REH_NS 10
`define T_REA_NS 20
`define T_WHR_NS 60
`define CYC_UP(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WP_CYC 8'(`CYC_UP(`T_WP_NS))
`define WH_CYC 8'(`CYC_UP(`T_WH_NS))
`define RP_CYC 8'(`CYC_UP(`T_RP_NS))
`define REH_CYC 8'(`CYC_UP(`T_REH_NS))
`define REA_CYC 8'(`CYC_UP(`T_REA_NS))
`define WHR_CYC 8'(`CYC_UP(`T_WHR_NS))

// ==========================================================
// NAND command codes
`define CMD_READ_MODE 8'h00
`define CMD_RAND_READ 8'h05
`define CMD_RAND_CONF 8'he0
`define CMD_STATUS 8'h70
`define CMD_STATUS_ENH 8'h78

// ==========================================================
// Status byte fields
`define SR_WP 7
`define SR_DIE_READY 6
`define SR_ARRAY_READY 5
`define SR_ECC_HI 4
`define SR_ECC_LO 3
`define SR_PRIOR 1
`define SR_FAIL 0

// ==========================================================
// APB register map
`define OFF_CTRL 12'h000
`define OFF_CMD 12'h004
`define OFF_ROW 12'h008
`define OFF_COL 12'h00c
`define OFF_STAT 12'h010
`define OFF_DATA 12'h014
`define CTRL_MULTI_DIE 0
`define CTRL_OTP 1
`define CTRL_CACHE 2
`define CTRL_W 3
`define ROW_W 24
`define COL_W 16
`define STAT_BUSY 0
`define STAT_REFUSED 1
`define STAT_STATUS_MODE 2
`define STAT_DIE_SEL 3

`endif

/* pkg/seq_if.sv */
// Link between the command engine and the pin sequencer.
// Assumes both ends run on pclk.
interface seq_if;
  logic req;
  nand_host_pkg::kind_type kind;
  logic [7:0] data;
  logic hold;
  logic done;
  logic [7:0] rdata;
  modport master (output req, kind, data, hold, input done, rdata);
  modport slave (input req, kind, data, hold, output done, rdata);
endinterface

/* rtl/nand_pin_sequencer.sv */
// Pin sequencer: one command, address, read, wait or live-status cycle per request.
// Assumes nand_io_in is synchronous to pclk.
`include "nand_host_regs.svh"

module nand_pin_sequencer (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  seq_if.slave link, // Requests from the command engine
  output logic nand_ce_n, // Chip select
  output logic nand_cle, // Command latch enable
  output logic nand_ale, // Address latch enable
  output logic nand_we_n, // Write strobe
  output logic nand_re_n, // Read strobe
  input wire logic [7:0] nand_io_in, // Bus level
  output logic [7:0] nand_io_out, // Bus drive value
  output logic nand_io_oe // Bus drive enable
);

  nand_host_pkg::seq_state_type state;
  nand_host_pkg::kind_type cur_kind;
  logic [7:0] cnt;

  // ==========================================================
  // Chip select follows the engine's busy level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      nand_ce_n <= 1'b1;
    else
      nand_ce_n <= !link.hold;
  end

  // ==========================================================
  // Strobe timing state machine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= nand_host_pkg::S_IDLE;
      cur_kind <= nand_host_pkg::K_CMD;
      cnt <= 8'h00;
      nand_cle <= 1'b0;
      nand_ale <= 1'b0;
      nand_we_n <= 1'b1;
      nand_re_n <= 1'b1;
      nand_io_out <= 8'h00;
      nand_io_oe <= 1'b0;
      link.done <= 1'b0;
      link.rdata <= 8'h00;
    end
    else
    begin
      link.done <= 1'b0;
      unique case (state)
        nand_host_pkg::S_IDLE:
        begin
          if (link.req)
          begin
            cur_kind <= link.kind;
            if (link.kind == nand_host_pkg::K_DELAY)
            begin
              cnt <= `WHR_CYC - 8'h01;
              state <= nand_host_pkg::S_WAIT;
            end
            else
              state <= nand_host_pkg::S_SETUP;
            if (link.kind == nand_host_pkg::K_CMD || link.kind == nand_host_pkg::K_ADDR)
            begin
              nand_cle <= (link.kind == nand_host_pkg::K_CMD);
              nand_ale <= (link.kind == nand_host_pkg::K_ADDR);
              nand_io_out <= link.data;
              nand_io_oe <= 1'b1;
            end
            else
              nand_io_oe <= 1'b0;
          end
        end
        nand_host_pkg::S_SETUP:
        begin
          state <= nand_host_pkg::S_LOW;
          if (cur_kind == nand_host_pkg::K_READ || cur_kind == nand_host_pkg::K_LIVE)
          begin
            nand_re_n <= 1'b0;
            cnt <= (cur_kind == nand_host_pkg::K_LIVE) ? `REA_CYC - 8'h01 : `RP_CYC - 8'h01;
          end
          else
          begin
            nand_we_n <= 1'b0;
            cnt <= `WP_CYC - 8'h01;
          end
        end
        nand_host_pkg::S_LOW:
        begin
          cnt <= cnt - 8'h01;
          if (cnt == 8'h00)
          begin
            cnt <= (cur_kind == nand_host_pkg::K_READ) ? `REH_CYC - 8'h01 : `WH_CYC - 8'h01;
            if (cur_kind == nand_host_pkg::K_LIVE)
              state <= nand_host_pkg::S_LIVE;
            else
              state <= nand_host_pkg::S_HIGH;
            if (cur_kind == nand_host_pkg::K_READ)
            begin
              link.rdata <= nand_io_in;
              nand_re_n <= 1'b1;
            end
            else
              nand_we_n <= 1'b1;
          end
        end
        nand_host_pkg::S_LIVE:
        begin
          // Strobe stays low; status updates are seen without a new edge
          link.rdata <= nand_io_in;
          if (nand_io_in[`SR_DIE_READY])
          begin
            nand_re_n <= 1'b1;
            cnt <= `REH_CYC - 8'h01;
            state <= nand_host_pkg::S_HIGH;
          end
        end
        nand_host_pkg::S_HIGH:
        begin
          cnt <= cnt - 8'h01;
          if (cnt == 8'h00)
          begin
            link.done <= 1'b1;
            nand_cle <= 1'b0;
            nand_ale <= 1'b0;
            state <= nand_host_pkg::S_IDLE;
          end
        end
        nand_host_pkg::S_WAIT:
        begin
          cnt <= cnt - 8'h01;
          if (cnt == 8'h00)
          begin
            link.done <= 1'b1;
            state <= nand_host_pkg::S_IDLE;
          end
        end
        default:
          state <= nand_host_pkg::S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Pin timing checks
  property p_we_width;
    @(posedge pclk) disable iff (!presetn)
    $fell(nand_we_n) |-> (!nand_we_n)[*4] ##1 nand_we_n;
  endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe low width wrong");

  property p_bus_released;
    @(posedge pclk) disable iff (!presetn)
    !nand_re_n |-> !nand_io_oe;
  endproperty
  a_bus_released: assert property (p_bus_released) else $error("bus driven while reading");

  property p_latch_excl;
    @(posedge pclk) disable iff (!presetn)
    !(nand_cle && nand_ale);
  endproperty
  a_latch_excl: assert property (p_latch_excl) else $error("command and address latch both high");

  property p_whr_wait;
    @(posedge pclk) disable iff (!presetn)
    (state == nand_host_pkg::S_IDLE && link.req && link.kind == nand_host_pkg::K_DELAY)
      |=> (!link.done)[*8] ##1 (!link.done)[*7] ##1 link.done;
  endproperty
  a_whr_wait: assert property (p_whr_wait) else $error("command-to-output wait wrong length");

endmodule

/* rtl/nand_status_host.sv */
// Host controller for NAND status reads, read mode and random data read.
// Assumes an APB master on pclk and one NAND target on the pin ports.
//
// The register addresses and the APB interface to the registers were decided locally.
`include "nand_host_regs.svh"

module nand_status_host (
  input wire logic pclk, // System clock, 250 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output logic nand_ce_n, // Chip select
  output logic nand_cle, // Command latch enable
  output logic nand_ale, // Address latch enable
  output logic nand_we_n, // Write strobe
  output logic nand_re_n, // Read strobe
  input wire logic [7:0] nand_io_in, // Bus level
  output logic [7:0] nand_io_out, // Bus drive value
  output logic nand_io_oe // Bus drive enable
);

  seq_if link ();

  logic [`CTRL_W-1:0] ctrl;
  logic [`ROW_W-1:0] row;
  logic [`COL_W-1:0] col;
  logic [7:0] status_byte;
  logic [7:0] data_byte;
  logic busy;
  logic refused;
  logic status_mode;
  logic die_selected;
  logic req;
  logic [2:0] step;
  nand_host_pkg::op_type op;
  nand_host_pkg::micro_type cur;
  logic wr_cmd;
  logic next_refuse;
  logic [2:0] next_step;
  logic [31:0] read_mux;
  logic [4:0] decoded;

  // ==========================================================
  // Address decode helper
  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
    addr_hit = (a == off);
  endfunction

  // Bus cycle list of each operation
  function automatic nand_host_pkg::micro_type op_step(input nand_host_pkg::op_type o, input logic [2:0] s,
                                                      input logic [`ROW_W-1:0] r, input logic [`COL_W-1:0] c);
    nand_host_pkg::micro_type m;
    m.kind = nand_host_pkg::K_CMD;
    m.data = `CMD_READ_MODE;
    m.last = 1'b1;
    m.to_status = 1'b0;
    unique case (o)
      nand_host_pkg::OP_STATUS, nand_host_pkg::OP_POLL:
      begin
        m.last = (s == 3'h2);
        m.to_status = (s == 3'h2);
        if (s == 3'h0)
          m.data = `CMD_STATUS;
        else if (s == 3'h1)
          m.kind = nand_host_pkg::K_DELAY;
        else
          m.kind = (o == nand_host_pkg::OP_POLL) ? nand_host_pkg::K_LIVE : nand_host_pkg::K_READ;
      end
      nand_host_pkg::OP_STATUS_ENH:
      begin
        m.last = (s == 3'h5);
        m.to_status = (s == 3'h5);
        unique case (s)
          3'h0: m.data = `CMD_STATUS_ENH;
          3'h1: begin m.kind = nand_host_pkg::K_ADDR; m.data = r[7:0]; end
          3'h2: begin m.kind = nand_host_pkg::K_ADDR; m.data = r[15:8]; end
          3'h3: begin m.kind = nand_host_pkg::K_ADDR; m.data = r[23:16]; end
          3'h4: m.kind = nand_host_pkg::K_DELAY;
          default: m.kind = nand_host_pkg::K_READ;
        endcase
      end
      nand_host_pkg::OP_RAND_READ:
      begin
        m.last = (s == 3'h4);
        unique case (s)
          3'h0: m.data = `CMD_RAND_READ;
          3'h1: begin m.kind = nand_host_pkg::K_ADDR; m.data = c[7:0]; end
          3'h2: begin m.kind = nand_host_pkg::K_ADDR; m.data = c[15:8]; end
          3'h3: m.data = `CMD_RAND_CONF;
          default: m.kind = nand_host_pkg::K_DELAY;
        endcase
      end
      nand_host_pkg::OP_READ_DATA:
      begin
        m.last = (s == 3'h2);
        if (s == 3'h1)
          m.kind = nand_host_pkg::K_DELAY;
        else if (s == 3'h2)
          m.kind = nand_host_pkg::K_READ;
      end
      default:
        m.last = 1'b1;
    endcase
    op_step = m;
  endfunction

  // ==========================================================
  // Sequencer hookup
  assign cur = op_step(op, step, row, col);
  assign link.req = req;
  assign link.kind = cur.kind;
  assign link.data = cur.data;
  assign link.hold = busy;

  nand_pin_sequencer u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .link(link),
    .nand_ce_n(nand_ce_n),
    .nand_cle(nand_cle),
    .nand_ale(nand_ale),
    .nand_we_n(nand_we_n),
    .nand_re_n(nand_re_n),
    .nand_io_in(nand_io_in),
    .nand_io_out(nand_io_out),
    .nand_io_oe(nand_io_oe)
  );

  // ==========================================================
  // Command acceptance
  assign wr_cmd = psel && penable && pready && pwrite && !pslverr && addr_hit(paddr, `OFF_CMD);

  always_comb
  begin
    next_refuse = busy || (pwdata[2:0] > 3'h5);
    if (pwdata[2:0] == 3'h1 && ctrl[`CTRL_OTP])
      next_refuse = 1'b1;
    if (pwdata[2:0] == 3'h3)
    begin
      if (ctrl[`CTRL_MULTI_DIE] && !die_selected)
        next_refuse = 1'b1;
      if (!(status_byte[`SR_DIE_READY] && (status_byte[`SR_ARRAY_READY] || ctrl[`CTRL_CACHE])))
        next_refuse = 1'b1;
    end
    // Leave status output with 00h only when it is on
    next_step = (pwdata[2:0] == 3'h4 && !status_mode) ? 3'h2 : 3'h0;
  end

  // ==========================================================
  // Operation engine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy <= 1'b0;
      refused <= 1'b0;
      req <= 1'b0;
      step <= 3'h0;
      op <= nand_host_pkg::OP_STATUS;
    end
    else
    begin
      req <= 1'b0;
      if (link.done && busy)
      begin
        if (cur.last)
          busy <= 1'b0;
        else
        begin
          step <= step + 3'h1;
          req <= 1'b1;
        end
      end
      if (wr_cmd)
      begin
        refused <= next_refuse;
        if (!next_refuse)
        begin
          busy <= 1'b1;
          req <= 1'b1;
          op <= nand_host_pkg::op_type'(pwdata[2:0]);
          step <= next_step;
        end
      end
    end
  end

  // ==========================================================
  // Results and output mode tracking
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_byte <= 8'h00;
      data_byte <= 8'h00;
      status_mode <= 1'b0;
      die_selected <= 1'b0;
    end
    else if (link.done && busy && cur.last)
    begin
      if (cur.to_status)
        status_byte <= link.rdata;
      if (op == nand_host_pkg::OP_READ_DATA)
        data_byte <= link.rdata;
      status_mode <= cur.to_status;
      if (op == nand_host_pkg::OP_STATUS_ENH)
        die_selected <= 1'b1;
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= '0;
      row <= '0;
      col <= '0;
    end
    else if (psel && penable && pready && pwrite && !pslverr)
    begin
      if (addr_hit(paddr, `OFF_CTRL))
        ctrl <= pwdata[`CTRL_W-1:0];
      if (addr_hit(paddr, `OFF_ROW))
        row <= pwdata[`ROW_W-1:0];
      if (addr_hit(paddr, `OFF_COL))
        col <= pwdata[`COL_W-1:0];
    end
  end

  // ==========================================================
  // Status field decode: each fail bit only counts while its ready bit is set
  assign decoded = {status_byte[`SR_FAIL] && status_byte[`SR_ARRAY_READY],
                    status_byte[`SR_PRIOR] && status_byte[`SR_DIE_READY],
                    status_byte[`SR_ECC_HI:`SR_ECC_LO],
                    !status_byte[`SR_WP]};

  always_comb
  begin
    read_mux = 32'h0000_0000;
    if (addr_hit(paddr, `OFF_CTRL))
      read_mux = {29'h0000_0000, ctrl};
    else if (addr_hit(paddr, `OFF_ROW))
      read_mux = {8'h00, row};
    else if (addr_hit(paddr, `OFF_COL))
      read_mux = {16'h0000, col};
    else if (addr_hit(paddr, `OFF_STAT))
      read_mux = {11'h000, decoded, status_byte, 4'h0, die_selected, status_mode, refused, busy};
    else if (addr_hit(paddr, `OFF_DATA))
      read_mux = {24'h00_0000, data_byte};
  end

  // ==========================================================
  // APB slave response, no wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(addr_hit(paddr, `OFF_CTRL) || addr_hit(paddr, `OFF_CMD) ||
                 addr_hit(paddr, `OFF_ROW) || addr_hit(paddr, `OFF_COL) ||
                 addr_hit(paddr, `OFF_STAT) || addr_hit(paddr, `OFF_DATA));
      if (psel && !penable && !pwrite)
        prdata <= read_mux;
    end
  end

  // ==========================================================
  // Checks
  property p_refuse_otp;
    @(posedge pclk) disable iff (!presetn)
    (wr_cmd && pwdata[2:0] == 3'h1 && ctrl[`CTRL_OTP]) |=> (refused && !req);
  endproperty
  a_refuse_otp: assert property (p_refuse_otp) else $error("78h issued in OTP mode");

  property p_refuse_unselected;
    @(posedge pclk) disable iff (!presetn)
    (wr_cmd && pwdata[2:0] == 3'h3 && ctrl[`CTRL_MULTI_DIE] && !die_selected) |=> (refused && !req);
  endproperty
  a_refuse_unselected: assert property (p_refuse_unselected) else $error("random read without 78h");

  property p_read_mode_first;
    @(posedge pclk) disable iff (!presetn)
    (wr_cmd && !busy && pwdata[2:0] == 3'h4 && status_mode)
      |=> (req && cur.kind == nand_host_pkg::K_CMD && cur.data == `CMD_READ_MODE);
  endproperty
  a_read_mode_first: assert property (p_read_mode_first) else $error("data read without 00h");

  property p_enh_row;
    @(posedge pclk) disable iff (!presetn)
    (link.done && busy && op == nand_host_pkg::OP_STATUS_ENH && step == 3'h0)
      |=> (req && cur.kind == nand_host_pkg::K_ADDR && cur.data == row[7:0]);
  endproperty
  a_enh_row: assert property (p_enh_row) else $error("78h not followed by row cycle");

  property p_rand_confirm;
    @(posedge pclk) disable iff (!presetn)
    (link.done && busy && op == nand_host_pkg::OP_RAND_READ && step == 3'h2)
      |=> (req && cur.kind == nand_host_pkg::K_CMD && cur.data == `CMD_RAND_CONF);
  endproperty
  a_rand_confirm: assert property (p_rand_confirm) else $error("E0h missing after column cycles");

  property p_status_capture;
    @(posedge pclk) disable iff (!presetn)
    (link.done && busy && cur.last && cur.to_status) |=> (status_byte == $past(link.rdata) && !busy);
  endproperty
  a_status_capture: assert property (p_status_capture) else $error("status byte not captured");

  property p_enh_selects;
    @(posedge pclk) disable iff (!presetn)
    (link.done && busy && cur.last && op == nand_host_pkg::OP_STATUS_ENH) |=> (status_mode && die_selected);
  endproperty
  a_enh_selects: assert property (p_enh_selects) else $error("78h did not select die");

  c_poll: cover property (@(posedge pclk) disable iff (!presetn)
    link.done && busy && cur.last && op == nand_host_pkg::OP_POLL);
  c_enh: cover property (@(posedge pclk) disable iff (!presetn)
    link.done && busy && cur.last && op == nand_host_pkg::OP_STATUS_ENH);
  c_rand: cover property (@(posedge pclk) disable iff (!presetn)
    link.done && busy && cur.last && op == nand_host_pkg::OP_RAND_READ);

endmodule

/* tb/nand_die_model.sv */
// Die model: one die answering status reads and random data read.
// Assumes host pins on its inputs; the bench sets the status byte.
module nand_die_model (
  input wire logic ce_n, // Chip select
  input wire logic cle, // Command latch
  input wire logic ale, // Address latch
  input wire logic we_n, // Write strobe
  input wire logic re_n, // Read strobe
  input wire logic [7:0] io, // Host drive value
  input wire logic [7:0] status, // Status byte
  output logic [7:0] dq // Die bus value
);
  timeunit 1ns;
  timeprecision 1ps;
  logic smode = 1'b0;
  logic [1:0] acnt = 2'h0;
  logic [15:0] col = 16'h0000;
  logic [7:0] last = 8'h00;
  logic [7:0] val;
  // ======================================
  // Latch on write strobe rise
  always @(posedge we_n)
  begin
    if (!ce_n && cle)
    begin
      acnt = 2'h0;
      if (io == 8'h70 || io == 8'h78)
        smode = 1'b1;
      if (io == 8'h00 || io == 8'he0)
        smode = 1'b0;
    end
    else if (!ce_n && ale)
    begin
      if (acnt == 2'h0)
        col[7:0] = io;
      if (acnt == 2'h1)
        col[15:8] = io;
      acnt = acnt + 2'h1;
    end
  end
  // Live output while strobed, else a changing level
  assign val = smode ? status : col[7:0] ^ col[15:8];
  assign dq = (!ce_n && !re_n) ? val : ~last;
  always @(posedge re_n)
    last = val;
endmodule

/* tb/tb.sv */
// Bench for the status host: APB stimulus, die model on the pins.
// Assumes design files and the die model compile first.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ce_n, cle, ale, we_n, re_n, oe;
  logic [7:0] io_out, dq, st;
  logic [15:0] col;
  int mismatches, checks;
  wire logic [7:0] io_in = oe ? io_out : dq;
  nand_status_host DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .nand_ce_n(ce_n),
    .nand_cle(cle), .nand_ale(ale), .nand_we_n(we_n), .nand_re_n(re_n), .nand_io_in(io_in),
    .nand_io_out(io_out), .nand_io_oe(oe));
  nand_die_model die (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n), .io(io_out),
    .status(st), .dq(dq));
  // ======================================
  // Tasks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      mismatches++;
      report_and_stop();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Start an operation, poll busy, leave the status word in rd
  task automatic run(input logic [2:0] op);
    int n;
    apb(1'b1, 12'h004, {29'h0, op});
    n = 0;
    do
    begin
      apb(1'b0, 12'h010, 32'h0);
      n++;
    end
    while (rd[0] !== 1'b0 && n < 100);
    if (rd[0] !== 1'b0)
    begin
      mismatches++;
      report_and_stop();
    end
  endtask
  function automatic logic [31:0] exp_stat(input logic [7:0] s, input logic [3:0] f);
    return {11'h000, s[0] & s[5], s[1] & s[6], s[4:3], ~s[7], s, 4'h0, f};
  endfunction
  // ======================================
  // Clock and watchdog
  initial
  begin
    pclk = 1'b0;
    forever
      #2 pclk = ~pclk;
  end
  initial
  begin
    #300000;
    mismatches++;
    report_and_stop();
  end
  // ======================================
  // Main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    st = 8'he0;
    checks = 0;
    mismatches = 0;
    void'($urandom(32'hde6093d9));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h010, 32'h0);
    check(rd, exp_stat(8'h00, 4'h0));
    apb(1'b0, 12'h018, 32'h0);
    check({31'h0, er}, 32'h1);
    run(3'h0);
    apb(1'b1, 12'h000, 32'h1);
    run(3'h3);
    check({31'h0, rd[1]}, 32'h1);
    apb(1'b1, 12'h000, 32'h2);
    run(3'h1);
    check({31'h0, rd[1]}, 32'h1);
    apb(1'b1, 12'h000, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      st <= (i < 2) ? {8{i[0]}} : 8'($urandom);
      run(3'h0);
      check(rd, exp_stat(st, 4'h4));
    end
    apb(1'b1, 12'h008, $urandom & 32'hffffff);
    st <= 8'h9b;
    run(3'h1);
    check(rd, exp_stat(8'h9b, 4'hc));
    for (int i = 0; i < 4; i++)
    begin
      col = (i == 0) ? 16'hffff : 16'($urandom);
      st <= (i == 3) ? 8'hc0 : 8'he0;
      apb(1'b1, 12'h000, {29'h0, i == 3, 2'h0});
      run(3'h0);
      apb(1'b1, 12'h00c, {16'h0, col});
      run(3'h3);
      run(3'h4);
      apb(1'b0, 12'h014, 32'h0);
      check(rd, {24'h0, col[7:0] ^ col[15:8]});
    end
    run(3'h0);
    run(3'h4);
    apb(1'b0, 12'h014, 32'h0);
    check(rd, {24'h0, col[7:0] ^ col[15:8]});
    apb(1'b1, 12'h000, 32'h0);
    st <= 8'h80;
    run(3'h0);
    run(3'h3);
    check({31'h0, rd[1]}, 32'h1);
    run(3'h6);
    check({31'h0, rd[1]}, 32'h1);
    fork
      run(3'h5);
      begin
        repeat (80) @(posedge pclk);
        st <= 8'he1;
      end
    join
    check(rd, exp_stat(8'he1, 4'hc));
    // Read mode leaves status output
    run(3'h2);
    check({31'h0, rd[2]}, 32'h0);
    // Command while busy is refused
    apb(1'b1, 12'h004, 32'h0);
    run(3'h0);
    check({31'h0, rd[1]}, 32'h1);
    // Reset after the last run has finished clears the status byte and flags
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h010, 32'h0);
    check(rd, exp_stat(8'h00, 4'h0));
    report_and_stop();
  end
endmodule
